// ---- design/gsm_pkg.sv ----
// Package with register map, field layout, states and carrier types of the global status and mode block.
// Operation
// RULE1 - Writing one to action_request starts request; self-clearing.
// RULE2 - Request examines queue commands and four channels.
// RULE3 - Each set command bit launches one process.
// RULE4 - Result flagged only after all processes finish.
// RULE5 - Serial rx/tx queue flags set on vector.
// RULE6 - Configuration queue flag set on new vector.
// RULE7 - Three peripheral flags: sync serial, local bus, port.
// RULE8 - Bit 0 flags successful completion.
// RULE9 - Bit 1 flags failed completion.
// RULE10 - Status register is write-one-to-clear.
// RULE11 - Interrupt line high while any status bit set.
// RULE12 - Ten interrupt queues are supported.
// RULE13 - Mode register fields at fixed positions, rest zero.
// RULE14 - Oscillator powerdown bit puts oscillator in standby.
// RULE15 - Divider field selects divide by 2, 4, 16.
// RULE16 - Local clock high one cycle, low stretched.
// RULE17 - Local clock driven onto dedicated output pin.
// RULE18 - Result mask set suppresses result vectors.
// RULE19 - Queue command loads base and length with request.
// RULE20 - Request bit reads one while processes run.
`default_nettype none
package gsm_pkg;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;

  localparam logic [31:0] CMD_RESET = 32'h00000200;
  localparam logic [31:0] CMD_WMASK = 32'hFF300201;
  localparam int CMD_AR_BIT = 0;
  localparam int CMD_MASK_BIT = 9;
  localparam int CMD_CFGQ_BIT = 21;
  localparam int CMD_PERQ_BIT = 20;
  localparam int CMD_TXQ_LSB = 24;
  localparam int CMD_RXQ_LSB = 28;

  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [31:0] STATUS_MASK = 32'hFF2D0003;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_FAIL_BIT = 1;
  localparam int ST_GPP_BIT = 16;
  localparam int ST_LBI_BIT = 18;
  localparam int ST_SSC_BIT = 19;
  localparam int ST_CFG_BIT = 21;
  localparam int ST_TX_LSB = 24;
  localparam int ST_RX_LSB = 28;

  localparam logic [31:0] MODE_RESET = 32'h00000000;
  localparam logic [31:0] MODE_WMASK = 32'h003FE007;
  localparam int MODE_OSCILLATOR_POWERDOWN_BIT = 21;
  localparam int MODE_DIV_LSB = 19;
  localparam int MODE_PER_LSB = 16;
  localparam int MODE_PRI_BIT = 15;
  localparam int MODE_CHN_LSB = 13;
  localparam int MODE_ENDIAN_BIT = 2;
  localparam int MODE_BURST_BIT = 1;
  localparam int MODE_CHAIN_BIT = 0;

  localparam int NUM_QUEUES = 10;
  localparam int NUM_CHANNELS = 4;
  localparam int NUM_PROCS = NUM_QUEUES + NUM_CHANNELS;

  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] DIV_BY16 = 2'h3;
  localparam logic [3:0] DIV2_LAST = 4'h1;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hF;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } gsm_state_t;

  typedef struct packed {
    logic [3:0] rx;
    logic [3:0] tx;
    logic cfg;
    logic sync_serial_unit;
    logic local_bus_unit;
    logic gp_port_unit;
  } gsm_vec_evt_t;

  typedef struct packed {
    logic oscillator_powerdown;
    logic [1:0] local_clock_divider;
    logic [2:0] peripheral_pin_config;
    logic priority_enable;
    logic [1:0] priority_channel_select;
    logic endian;
    logic demux_burst_enable;
    logic chain_end_control;
  } gsm_mode_t;
endpackage
`default_nettype wire

// ---- design/gsm_clk_div.sv ----
// Local bus clock divider producing a clock high for one cycle per period, asymmetric when dividing by 4 or 16, and a matching enable pulse.
`default_nettype none
module gsm_clk_div (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] div_sel,
  output logic local_clock_out,
  output logic local_bus_clock
);
  typedef struct packed {
    logic [3:0] cnt;
    logic clk_out;
  } gsm_div_state_t;

  gsm_div_state_t s_q;
  gsm_div_state_t s_d;
  logic [3:0] last;

  always_comb
  begin
    unique case (div_sel)
      gsm_pkg::DIV_BY4: last = gsm_pkg::DIV4_LAST; // [RULE15]
      gsm_pkg::DIV_BY16: last = gsm_pkg::DIV16_LAST; // [RULE15]
      default: last = gsm_pkg::DIV2_LAST; // [RULE15]
    endcase
    s_d = s_q;
    // A changed divider could leave the count above the new limit, so wrap on reaching or passing it.
    if (s_q.cnt >= last)
    begin
      s_d.cnt = 4'h0;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
    s_d.clk_out = (s_d.cnt == 4'h0); // [RULE16]
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign local_clock_out = s_q.clk_out; // [RULE17]
  assign local_bus_clock = s_q.clk_out;
endmodule
`default_nettype wire

// ---- design/gsm_global_ctrl.sv ----
// Global command, status and mode registers with action request sequencing and local clock generation.
`default_nettype none
module gsm_global_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] channel_cmd_pending,
  input wire gsm_pkg::gsm_vec_evt_t vec_written,
  input wire logic [13:0] proc_done,
  input wire logic [13:0] proc_fail,
  output logic [13:0] proc_launch,
  output logic result_vec_req,
  output logic result_vec_fail,
  output logic inta,
  output gsm_pkg::gsm_mode_t mode,
  output logic local_clock_out,
  output logic local_bus_clock
);
  typedef struct packed {
    gsm_pkg::gsm_state_t fsm;
    logic [31:0] cmd;
    logic [31:0] status;
    logic [31:0] mode;
    logic [13:0] pending;
    logic any_fail;
    logic [13:0] launch;
    logic vec_req;
    logic vec_fail;
    logic [31:0] rdata;
  } gsm_ctrl_state_t;

  gsm_ctrl_state_t s_q;
  gsm_ctrl_state_t s_d;
  logic wr_cmd;
  logic wr_status;
  logic wr_mode;
  logic [31:0] set_bits;
  logic [13:0] still_pending;
  logic [9:0] queue_cmds;

  assign wr_cmd = reg_wr && (reg_addr == gsm_pkg::ADDR_CMD);
  assign wr_status = reg_wr && (reg_addr == gsm_pkg::ADDR_STATUS);
  assign wr_mode = reg_wr && (reg_addr == gsm_pkg::ADDR_MODE);

  always_comb
  begin
    s_d = s_q;
    set_bits = '0;
    s_d.launch = '0;
    s_d.vec_req = 1'b0;
    s_d.vec_fail = 1'b0;
    still_pending = s_q.pending & ~proc_done;
    // Queue commands come from the write itself so a request and its commands may share one write.
    queue_cmds = {reg_wdata[gsm_pkg::CMD_RXQ_LSB +: 4], reg_wdata[gsm_pkg::CMD_TXQ_LSB +: 4],
      reg_wdata[gsm_pkg::CMD_CFGQ_BIT], reg_wdata[gsm_pkg::CMD_PERQ_BIT]}; // [RULE2] [RULE12]

    if (wr_cmd)
    begin
      // The request bit is kept out of the stored word; it only mirrors the running sequence.
      s_d.cmd = (reg_wdata & gsm_pkg::CMD_WMASK) & ~32'h00000001; // [RULE1]
    end
    if (wr_mode)
    begin
      s_d.mode = reg_wdata & gsm_pkg::MODE_WMASK; // [RULE13]
    end

    unique case (s_q.fsm)
      gsm_pkg::ST_IDLE:
      begin
        // A request written while a sequence runs is ignored; software waits for the request bit to drop.
        if (wr_cmd && reg_wdata[gsm_pkg::CMD_AR_BIT]) // [RULE1]
        begin
          s_d.pending = {queue_cmds, channel_cmd_pending}; // [RULE2] [RULE3]
          s_d.launch = {queue_cmds, channel_cmd_pending}; // [RULE3] [RULE19]
          s_d.any_fail = 1'b0;
          s_d.fsm = gsm_pkg::ST_RUN;
        end
      end
      gsm_pkg::ST_RUN:
      begin
        s_d.any_fail = s_q.any_fail | (|(proc_fail & s_q.pending & proc_done));
        s_d.pending = still_pending;
        if (still_pending == '0) // [RULE4]
        begin
          s_d.fsm = gsm_pkg::ST_IDLE; // [RULE20]
          if (s_d.any_fail)
          begin
            set_bits[gsm_pkg::ST_FAIL_BIT] = 1'b1; // [RULE9]
          end
          else
          begin
            set_bits[gsm_pkg::ST_DONE_BIT] = 1'b1; // [RULE8]
          end
          s_d.vec_req = ~s_q.cmd[gsm_pkg::CMD_MASK_BIT]; // [RULE18]
          s_d.vec_fail = s_d.any_fail & ~s_q.cmd[gsm_pkg::CMD_MASK_BIT]; // [RULE18]
        end
      end
    endcase

    set_bits[gsm_pkg::ST_RX_LSB +: 4] = vec_written.rx; // [RULE5]
    set_bits[gsm_pkg::ST_TX_LSB +: 4] = vec_written.tx; // [RULE5]
    set_bits[gsm_pkg::ST_CFG_BIT] = vec_written.cfg; // [RULE6]
    set_bits[gsm_pkg::ST_SSC_BIT] = vec_written.sync_serial_unit; // [RULE7]
    set_bits[gsm_pkg::ST_LBI_BIT] = vec_written.local_bus_unit; // [RULE7]
    set_bits[gsm_pkg::ST_GPP_BIT] = vec_written.gp_port_unit; // [RULE7]

    // A new event in the clearing cycle survives because the set term is applied after the clear.
    if (wr_status)
    begin
      s_d.status = s_q.status & ~reg_wdata; // [RULE10]
    end
    s_d.status = (s_d.status | set_bits) & gsm_pkg::STATUS_MASK; // [RULE10]

    s_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        gsm_pkg::ADDR_CMD: s_d.rdata = s_q.cmd | {31'h0, s_q.fsm == gsm_pkg::ST_RUN}; // [RULE20]
        gsm_pkg::ADDR_STATUS: s_d.rdata = s_q.status;
        gsm_pkg::ADDR_MODE: s_d.rdata = s_q.mode;
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q.fsm <= gsm_pkg::ST_IDLE;
      s_q.cmd <= gsm_pkg::CMD_RESET;
      s_q.status <= gsm_pkg::STATUS_RESET;
      s_q.mode <= gsm_pkg::MODE_RESET;
      s_q.pending <= '0;
      s_q.any_fail <= 1'b0;
      s_q.launch <= '0;
      s_q.vec_req <= 1'b0;
      s_q.vec_fail <= 1'b0;
      s_q.rdata <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign proc_launch = s_q.launch;
  assign result_vec_req = s_q.vec_req;
  assign result_vec_fail = s_q.vec_fail;
  assign inta = |s_q.status; // [RULE11]

  assign mode.oscillator_powerdown = s_q.mode[gsm_pkg::MODE_OSCILLATOR_POWERDOWN_BIT]; // [RULE14]
  assign mode.local_clock_divider = s_q.mode[gsm_pkg::MODE_DIV_LSB +: 2];
  assign mode.peripheral_pin_config = s_q.mode[gsm_pkg::MODE_PER_LSB +: 3];
  assign mode.priority_enable = s_q.mode[gsm_pkg::MODE_PRI_BIT];
  assign mode.priority_channel_select = s_q.mode[gsm_pkg::MODE_CHN_LSB +: 2];
  assign mode.endian = s_q.mode[gsm_pkg::MODE_ENDIAN_BIT];
  assign mode.demux_burst_enable = s_q.mode[gsm_pkg::MODE_BURST_BIT];
  assign mode.chain_end_control = s_q.mode[gsm_pkg::MODE_CHAIN_BIT];

  gsm_clk_div u_clk_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .div_sel(s_q.mode[gsm_pkg::MODE_DIV_LSB +: 2]),
    .local_clock_out(local_clock_out),
    .local_bus_clock(local_bus_clock)
  );
endmodule
`default_nettype wire

// ---- sim/gsm_global_ctrl_monitor.sv ----
// Checker of the global status and mode block ports.
`default_nettype none
module gsm_global_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [13:0] proc_launch,
  input wire logic inta,
  input wire gsm_pkg::gsm_mode_t mode,
  input wire logic local_clock_out,
  input wire logic local_bus_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_req;
    reg_wr && reg_addr == 8'h00 && reg_wdata[0];
  endsequence
  a_inta_level: assert property (reg_rd && reg_addr == 8'h04 |=> (reg_rdata != 32'h0) == $past(inta))
    else $error("inta and status disagree");
  a_launch_cause: assert property (proc_launch != 14'h0 |-> $past(reg_wr && reg_addr == 8'h00 && reg_wdata[0]))
    else $error("launch without request");
  a_launch_map: assert property (s_req ##1 proc_launch != 14'h0 |->
    proc_launch[13:4] == {$past(reg_wdata[31:24]), $past(reg_wdata[21:20])}) else $error("launch bits wrong");
  a_launch_pulse: assert property (proc_launch != 14'h0 |=> proc_launch == 14'h0)
    else $error("launch too long");
  a_mode_write: assert property (reg_wr && reg_addr == 8'h08 |=>
    mode == {$past(reg_wdata[21:13]), $past(reg_wdata[2:0])}) else $error("mode fields wrong");
  a_clk_high: assert property ($rose(local_clock_out) |=> !local_clock_out)
    else $error("local clock high too long");
  a_clk_low: assert property ($fell(local_clock_out) |-> ##[1:17] local_clock_out)
    else $error("local clock low too long");
  a_clk_pin: assert property (local_clock_out == local_bus_clock)
    else $error("clock pins differ");
endmodule
bind gsm_global_ctrl gsm_global_ctrl_monitor gsm_global_ctrl_monitor_i (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .proc_launch, .inta, .mode, .local_clock_out, .local_bus_clock);
`default_nettype wire

// ---- sim/gsm_proc_model.sv ----
// Model of the configuration processes that answer launches.
`default_nettype none
module gsm_proc_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [13:0] proc_launch,
  input wire logic [13:0] fail_sel,
  input wire logic stall,
  output logic [13:0] proc_done,
  output logic [13:0] proc_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] pend_q;
  logic [13:0] one;
  // Processes end one at a time, so only the last one may release the result.
  assign one = pend_q & (~pend_q + 14'h0001);
  always_ff @(posedge clk_sys)
  begin
    proc_done <= 14'h0000;
    proc_fail <= 14'h0000;
    if (sys_rst)
      pend_q <= 14'h0000;
    else if (proc_launch != 14'h0000)
      pend_q <= proc_launch;
    else if (!stall && pend_q != 14'h0000)
    begin
      proc_done <= one;
      proc_fail <= one & fail_sel;
      pend_q <= pend_q & ~one;
    end
  end
endmodule
`default_nettype wire

// ---- sim/gsm_global_ctrl_bench.sv ----
// Testbench of the global status and mode block.
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module gsm_global_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, sys_rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0, stall = 1'h1, inta, rv_req, rv_fail, lco, lbc;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, v;
  logic [3:0] chp = 4'h0;
  logic [13:0] done, fail, launch, fsel = 14'h0, seen = 14'h0;
  gsm_pkg::gsm_vec_evt_t vec = 12'h000;
  gsm_pkg::gsm_mode_t mode;
  int failures = 0, check_count = 0, res_n = 0, res_f = 0, n;
  gsm_global_ctrl gsm_global_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .channel_cmd_pending(chp), .vec_written(vec), .proc_done(done),
    .proc_fail(fail), .proc_launch(launch), .result_vec_req(rv_req), .result_vec_fail(rv_fail), .inta(inta),
    .mode(mode), .local_clock_out(lco), .local_bus_clock(lbc));
  gsm_proc_model gsm_proc_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .proc_launch(launch), .fail_sel(fsel),
    .stall(stall), .proc_done(done), .proc_fail(fail));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    seen <= seen | launch;
    if (rv_req) res_n <= res_n + 1;
    if (rv_req && rv_fail) res_f <= res_f + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_s <= 1'h1;
    addr <= a;
    wd <= d;
    @(posedge clk_sys);
    wr_s <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    rd_s <= 1'h1;
    addr <= a;
    @(posedge clk_sys);
    rd_s <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(nm, e, v)
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Polls status with a bound so a lost completion cannot hang the run.
  task automatic wait_res();
    n = 0;
    do
    begin
      rd(8'h04);
      n++;
    end
    while (v[1:0] === 2'h0 && n < 60);
    if (n >= 60)
    begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic period(output int p);
    p = 0;
    repeat (40) if (lco !== 1'h1) @(posedge clk_sys) #1;
    do
    begin
      @(posedge clk_sys) #1;
      p++;
    end
    while (lco !== 1'h1 && p < 40);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rchk("status", 8'h04, 32'h0);
    rchk("command", 8'h00, 32'h200);
    rchk("unmapped", 8'h0C, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rchk("mode", 8'h08, 32'h003FE007);
    `CHK("mode pins", 12'hFFF, mode)
    for (int i = 1; i < 4; i++)
    begin
      wr(8'h08, 32'(i) << 19);
      period(n);
      period(n);
      `CHK("divide", (i == 3) ? 16 : 2 * i, n)
    end
    $display("test mode done");
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_sys);
      vec <= 12'h001 << i;
      @(posedge clk_sys);
      vec <= 12'h000;
      rchk("flag", 8'h04, 32'h1 << ((i == 0) ? 16 : (i < 3) ? 17 + i : (i == 3) ? 21 : 20 + i));
      `CHK("inta set", 1'h1, inta)
      wr(8'h04, ~v);
      rchk("w0 keeps", 8'h04, v);
      wr(8'h04, v);
      rchk("w1 clears", 8'h04, 32'h0);
      `CHK("inta clear", 1'h0, inta)
    end
    $display("test flags done");
    @(posedge clk_sys);
    chp <= 4'h5;
    wr(8'h00, 32'h10100001);
    rchk("busy", 8'h00, 32'h10100001);
    rchk("early", 8'h04, 32'h0);
    stall <= 1'h0;
    wait_res();
    `CHK("ack", 32'h1, v)
    `CHK("launched", 14'h0415, seen)
    `CHK("result vector", 1, res_n)
    rchk("self clear", 8'h00, 32'h10100000);
    wr(8'h04, 32'h3);
    fsel <= 14'h0010;
    wr(8'h00, 32'h00100201);
    wait_res();
    `CHK("failed", 32'h2, v)
    `CHK("masked", 1, res_n)
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h00100001);
    wait_res();
    `CHK("failed again", 32'h2, v)
    `CHK("fail vector", 1, res_f)
    `CHK("vectors", 2, res_n)
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h0);
    rchk("zero idle", 8'h04, 32'h0);
    $display("test request done");
    @(posedge clk_sys);
    vec <= 12'h800;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    vec <= 12'h000;
    sys_rst <= 1'h0;
    rchk("reset status", 8'h04, 32'h0);
    `CHK("reset inta", 1'h0, inta)
    rchk("reset mode", 8'h08, 32'h0);
    rchk("reset command", 8'h00, 32'h200);
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
